// ---- wss_pkg.sv ----
package wss_pkg;

  // Register indices; byte address is four times the index
  localparam logic [7:0] SLOT_SEVEN_IDX = 8'h15;
  localparam logic [7:0] SLOT_EIGHT_IDX = 8'h16;
  localparam logic [7:0] STATUS_IDX = 8'h1F;

  localparam logic [7:0] SLOT_RESET = 8'h00;
  localparam int SLOT_DELAY_BIT = 7;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_INDEX_LSB = 1;
  localparam int STAT_DELAY_BIT = 4;

  localparam logic [2:0] FIRST_SLOT = 3'h0;
  localparam logic [2:0] LAST_SLOT = 3'h7;

  // One delay count is 10 ms at a 25 ns clock
  localparam int DELAY_UNIT_NS = 10000000;
  localparam int CLK_PERIOD_NS = 25;
  localparam int DELAY_UNIT_CYCLES = DELAY_UNIT_NS / CLK_PERIOD_NS;
  localparam int TICK_WIDTH = 19;

  typedef struct packed {
    logic delay_sel;
    logic [6:0] value;
  } wss_slot_t;

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_FETCH = 4'b0010,
    ST_PLAY = 4'b0100,
    ST_WAIT = 4'b1000
  } wss_state_t;

  function automatic logic [7:0] byte_addr(input logic [7:0] idx);
    byte_addr = {idx[5:0], 2'b00};
  endfunction

endpackage

// ---- wss_tick_div.sv ----
`timescale 1ns/1ps
module wss_tick_div #(
  parameter int TICK_CYCLES = wss_pkg::DELAY_UNIT_CYCLES
) (
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_restart,
  output logic o_tick
);

  logic [wss_pkg::TICK_WIDTH-1:0] cnt_ff;
  logic [wss_pkg::TICK_WIDTH-1:0] nxt_cnt;
  logic at_end;

  assign at_end = (cnt_ff == wss_pkg::TICK_WIDTH'(TICK_CYCLES - 1));
  assign o_tick = at_end & ~i_restart;
  assign nxt_cnt = (i_restart | at_end) ? '0 : cnt_ff + 1'b1;

  always_ff @(posedge i_clk)
  begin
    if (i_reset)
      cnt_ff <= '0;
    else
      cnt_ff <= nxt_cnt;
  end

endmodule

// ---- wss_seq_slots.sv ----
// The implementer's own choice: the APB register port.
`timescale 1ns/1ps
// Functional notes
// - Slot top bit set: value is idle delay, 10 ms per count, no waveform.
// - Slot top bit clear: bits 6..0 index a library waveform.
// - Start command begins playback at the first sequence slot.
// - After a waveform ends, advance to next slot if it is non-zero.
// - Sequence ends at first zero slot or after all eight slots.
// - A zero slot stops the sequencer without playing anything.
module wss_seq_slots #(
  parameter int TICK_CYCLES = wss_pkg::DELAY_UNIT_CYCLES
) (
  input wire logic I_CLK_SYS,
  input wire logic I_RESET,
  input wire logic I_PSEL,
  input wire logic I_PENABLE,
  input wire logic I_PWRITE,
  input wire logic [7:0] I_PADDR,
  input wire logic [31:0] I_PWDATA,
  input wire logic [3:0] I_PSTRB,
  output logic O_PREADY,
  output logic [31:0] O_PRDATA,
  output logic O_PSLVERR,
  input wire logic I_START,
  input wire logic [47:0] I_SLOTS_EARLY,
  output logic O_PLAY_STROBE,
  output logic [6:0] O_PLAY_ID,
  input wire logic I_PLAY_DONE,
  output logic O_DELAY_ACTIVE,
  output logic O_SEQ_BUSY
);

  wss_pkg::wss_slot_t slot_seven_ff;
  wss_pkg::wss_slot_t slot_eight_ff;
  wss_pkg::wss_state_t state_ff;
  wss_pkg::wss_state_t nxt_state;
  logic [2:0] idx_ff;
  logic [2:0] nxt_idx;
  logic [6:0] delay_ff;
  logic [6:0] nxt_delay;
  logic play_ff;
  logic nxt_play;
  logic [6:0] play_id_ff;
  logic [6:0] nxt_play_id;
  logic [31:0] prdata_ff;
  logic [31:0] nxt_prdata;

  // Bus decode
  logic setup;
  logic access;
  logic hit_seven;
  logic hit_eight;
  logic hit_status;
  logic mapped;
  logic wr_seven;
  logic wr_eight;
  logic [31:0] status_word;

  assign setup = I_PSEL & ~I_PENABLE;
  assign access = I_PSEL & I_PENABLE;
  assign hit_seven = (I_PADDR == wss_pkg::byte_addr(wss_pkg::SLOT_SEVEN_IDX));
  assign hit_eight = (I_PADDR == wss_pkg::byte_addr(wss_pkg::SLOT_EIGHT_IDX));
  assign hit_status = (I_PADDR == wss_pkg::byte_addr(wss_pkg::STATUS_IDX));
  assign mapped = hit_seven | hit_eight | hit_status;
  // Status is read only, so a write to it is an error too
  assign O_PREADY = 1'b1;
  assign O_PSLVERR = access & (~mapped | (I_PWRITE & hit_status));
  assign wr_seven = access & I_PWRITE & hit_seven & I_PSTRB[0];
  assign wr_eight = access & I_PWRITE & hit_eight & I_PSTRB[0];

  assign status_word = {27'h000_0000,
                        (state_ff == wss_pkg::ST_WAIT),
                        idx_ff,
                        (state_ff != wss_pkg::ST_IDLE)};

  // Read data is latched in the setup phase so the access phase needs no wait
  assign nxt_prdata = ~(setup & ~I_PWRITE) ? prdata_ff :
                      hit_seven ? {24'h00_0000, slot_seven_ff} :
                      hit_eight ? {24'h00_0000, slot_eight_ff} :
                      hit_status ? status_word : 32'h0000_0000;

  // Sequence walk
  logic [63:0] all_slots;
  wss_pkg::wss_slot_t cur_slot;
  logic last_slot;
  logic tick;
  logic restart_tick;

  assign all_slots = {slot_eight_ff, slot_seven_ff, I_SLOTS_EARLY};
  assign cur_slot = all_slots[{idx_ff, 3'b000} +: 8];
  assign last_slot = (idx_ff == wss_pkg::LAST_SLOT);
  assign restart_tick = (state_ff != wss_pkg::ST_WAIT);

  wss_tick_div #(
    .TICK_CYCLES(TICK_CYCLES)
  ) u_tick (
    .i_clk(I_CLK_SYS),
    .i_reset(I_RESET),
    .i_restart(restart_tick),
    .o_tick(tick)
  );

  always_comb
  begin
    nxt_state = state_ff;
    nxt_idx = idx_ff;
    nxt_delay = delay_ff;
    nxt_play = 1'b0;
    nxt_play_id = play_id_ff;
    unique case (state_ff)
      wss_pkg::ST_IDLE:
      begin
        // Start while busy is ignored rather than restarting mid-effect
        if (I_START)
        begin
          nxt_idx = wss_pkg::FIRST_SLOT;
          nxt_state = wss_pkg::ST_FETCH;
        end
      end
      wss_pkg::ST_FETCH:
      begin
        if (cur_slot == wss_wss_zero())
          nxt_state = wss_pkg::ST_IDLE;
        else if (cur_slot.delay_sel)
        begin
          nxt_delay = cur_slot.value;
          nxt_state = wss_pkg::ST_WAIT;
        end
        else
        begin
          nxt_play = 1'b1;
          nxt_play_id = cur_slot.value;
          nxt_state = wss_pkg::ST_PLAY;
        end
      end
      wss_pkg::ST_PLAY:
      begin
        if (I_PLAY_DONE)
        begin
          nxt_state = last_slot ? wss_pkg::ST_IDLE : wss_pkg::ST_FETCH;
          nxt_idx = last_slot ? idx_ff : idx_ff + 3'h1;
        end
      end
      wss_pkg::ST_WAIT:
      begin
        if (delay_ff == 7'h00)
        begin
          nxt_state = last_slot ? wss_pkg::ST_IDLE : wss_pkg::ST_FETCH;
          nxt_idx = last_slot ? idx_ff : idx_ff + 3'h1;
        end
        else if (tick)
          nxt_delay = delay_ff - 7'h01;
      end
      default:
        nxt_state = wss_pkg::ST_IDLE;
    endcase
  end

  function automatic wss_pkg::wss_slot_t wss_wss_zero();
    wss_wss_zero = wss_pkg::wss_slot_t'(wss_pkg::SLOT_RESET);
  endfunction

  always_ff @(posedge I_CLK_SYS)
  begin
    if (I_RESET)
    begin
      slot_seven_ff <= wss_pkg::wss_slot_t'(wss_pkg::SLOT_RESET);
      slot_eight_ff <= wss_pkg::wss_slot_t'(wss_pkg::SLOT_RESET);
      prdata_ff <= 32'h0000_0000;
    end
    else
    begin
      if (wr_seven)
        slot_seven_ff <= wss_pkg::wss_slot_t'(I_PWDATA[7:0]);
      if (wr_eight)
        slot_eight_ff <= wss_pkg::wss_slot_t'(I_PWDATA[7:0]);
      prdata_ff <= nxt_prdata;
    end
  end

  always_ff @(posedge I_CLK_SYS)
  begin
    if (I_RESET)
    begin
      state_ff <= wss_pkg::ST_IDLE;
      idx_ff <= wss_pkg::FIRST_SLOT;
      delay_ff <= 7'h00;
      play_ff <= 1'b0;
      play_id_ff <= 7'h00;
    end
    else
    begin
      state_ff <= nxt_state;
      idx_ff <= nxt_idx;
      delay_ff <= nxt_delay;
      play_ff <= nxt_play;
      play_id_ff <= nxt_play_id;
    end
  end

  assign O_PRDATA = prdata_ff;
  assign O_PLAY_STROBE = play_ff;
  assign O_PLAY_ID = play_id_ff;
  // Engine stays silent through a delay slot
  assign O_DELAY_ACTIVE = (state_ff == wss_pkg::ST_WAIT);
  assign O_SEQ_BUSY = (state_ff != wss_pkg::ST_IDLE);

endmodule

// ---- wss_seq_slots_props.sv ----
`timescale 1ns/1ps
module wss_seq_slots_props #(
  parameter int TICK_CYCLES = 4
) (
  input wire logic I_CLK_SYS,
  input wire logic I_RESET,
  input wire logic I_START,
  input wire logic [47:0] I_SLOTS_EARLY,
  input wire logic I_PLAY_DONE,
  input wire logic O_PLAY_STROBE,
  input wire logic O_DELAY_ACTIVE,
  input wire logic O_SEQ_BUSY
);
  default clocking @(posedge I_CLK_SYS); endclocking
  default disable iff (I_RESET);
  wire go = I_START && !O_SEQ_BUSY;
  wire [7:0] s1 = I_SLOTS_EARLY[7:0];
  logic [15:0] dcnt_ff;
  // Counts only while a delay runs, so each delay is measured alone
  always_ff @(posedge I_CLK_SYS)
    dcnt_ff <= (O_DELAY_ACTIVE && !I_RESET) ? dcnt_ff + 16'h0001 : 16'h0000;
  property p_first_wave; go && s1 != 8'h00 && !s1[7] |-> ##2 O_PLAY_STROBE; endproperty
  a_first_wave: assert property (p_first_wave) else $error("first slot not played");
  property p_first_dly; go && s1[7] && s1[6:0] != 7'h00 |-> ##2 O_DELAY_ACTIVE; endproperty
  a_first_dly: assert property (p_first_dly) else $error("delay slot not idled");
  property p_dly_len; $fell(O_DELAY_ACTIVE) |-> dcnt_ff >= TICK_CYCLES; endproperty
  a_dly_len: assert property (p_dly_len) else $error("delay too short");
  property p_quiet; O_DELAY_ACTIVE |-> !O_PLAY_STROBE; endproperty
  a_quiet: assert property (p_quiet) else $error("waveform during delay");
  property p_pulse; O_PLAY_STROBE |-> O_SEQ_BUSY ##1 !O_PLAY_STROBE; endproperty
  a_pulse: assert property (p_pulse) else $error("bad play strobe");
  property p_hold; O_PLAY_STROBE ##1 !I_PLAY_DONE [*3] |-> !O_PLAY_STROBE && O_SEQ_BUSY; endproperty
  a_hold: assert property (p_hold) else $error("advanced before done");
  property p_zero; go && s1 == 8'h00 |-> ##2 !O_SEQ_BUSY && !O_PLAY_STROBE; endproperty
  a_zero: assert property (p_zero) else $error("zero slot did not stop");
  property p_end; $fell(O_SEQ_BUSY) |-> !$past(O_PLAY_STROBE); endproperty
  a_end: assert property (p_end) else $error("ended while starting a play");
endmodule
bind wss_seq_slots wss_seq_slots_props #(.TICK_CYCLES(TICK_CYCLES)) u_props (
  .I_CLK_SYS(I_CLK_SYS), .I_RESET(I_RESET), .I_START(I_START),
  .I_SLOTS_EARLY(I_SLOTS_EARLY), .I_PLAY_DONE(I_PLAY_DONE), .O_PLAY_STROBE(O_PLAY_STROBE),
  .O_DELAY_ACTIVE(O_DELAY_ACTIVE), .O_SEQ_BUSY(O_SEQ_BUSY));

// ---- wss_seq_slots_tb_top.sv ----
`timescale 1ns/1ps
module wss_seq_slots_tb_top;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic pen = 1'b0;
  logic pwr = 1'b0;
  logic start = 1'b0;
  logic done = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [47:0] slots = 48'h0000_0000_0000;
  logic pready, pslverr, strobe, dact, busy, er;
  logic [6:0] pid;
  logic [31:0] prdata, rd, v, r;
  logic [31:0] seed = 32'hf44f;
  logic [7:0] sq [8];
  int n_errors = 0;
  int checked = 0;
  int k;
  initial forever #12.5 clk = ~clk;
  wss_seq_slots #(.TICK_CYCLES(4)) dut (.I_CLK_SYS(clk), .I_RESET(rst), .I_PSEL(psel),
    .I_PENABLE(pen), .I_PWRITE(pwr), .I_PADDR(paddr), .I_PWDATA(pwdata), .I_PSTRB(4'hf),
    .O_PREADY(pready), .O_PRDATA(prdata), .O_PSLVERR(pslverr), .I_START(start),
    .I_SLOTS_EARLY(slots), .O_PLAY_STROBE(strobe), .O_PLAY_ID(pid), .I_PLAY_DONE(done),
    .O_DELAY_ACTIVE(dact), .O_SEQ_BUSY(busy));
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task test_done();
    $display("checked=%0d n_errors=%0d", checked, n_errors);
    if (n_errors == 0 && checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      n_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task tmo();
    if (k >= 200)
    begin
      n_errors++;
      test_done();
    end
  endtask
  // Master waits for ready; only the bound ends a hang
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pen <= 1'b0;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    k = 0;
    do
    begin
      @(posedge clk);
      k++;
    end
    while (pready !== 1'b1 && k < 200);
    tmo();
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  task run_seq();
    int n;
    @(posedge clk);
    slots <= {sq[5], sq[4], sq[3], sq[2], sq[1], sq[0]};
    apb(1'b1, 8'h54, {24'h00_0000, sq[6]});
    apb(1'b1, 8'h58, {24'h00_0000, sq[7]});
    @(posedge clk);
    start <= 1'b1;
    @(posedge clk);
    start <= 1'b0;
    for (int i = 0; i < 8; i++)
    begin
      if (sq[i] == 8'h00)
        break;
      k = 0;
      while ((sq[i][7] ? dact : strobe) !== 1'b1 && k < 200)
      begin
        @(negedge clk);
        k++;
      end
      tmo();
      if (sq[i][7])
      begin
        n = 0;
        while (dact === 1'b1 && n < 200)
        begin
          @(negedge clk);
          n++;
        end
        chk(n >= sq[i][6:0] * 4 && n <= sq[i][6:0] * 4 + 2, 1);
      end
      else
      begin
        chk(pid, sq[i][6:0]);
        repeat (rnd() % 6 + 1) @(posedge clk);
        done <= 1'b1;
        @(posedge clk);
        done <= 1'b0;
      end
    end
    // Nothing may play once the stop marker or the last slot is reached
    for (k = 0; busy === 1'b1 && k < 200; k++)
    begin
      @(negedge clk);
      chk(strobe, 0);
    end
    tmo();
  endtask
  initial
  begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    apb(1'b0, 8'h54, 32'h0000_0000);
    chk(rd, 0);
    apb(1'b0, 8'h58, 32'h0000_0000);
    chk(rd, 0);
    repeat (4)
    begin
      v = rnd();
      apb(1'b1, 8'h54, v);
      apb(1'b1, 8'h58, ~v);
      apb(1'b0, 8'h54, 32'h0000_0000);
      chk(rd, {24'h00_0000, v[7:0]});
      apb(1'b0, 8'h58, 32'h0000_0000);
      chk(rd, {24'h00_0000, ~v[7:0]});
    end
    apb(1'b0, 8'h60, 32'h0000_0000);
    chk(er, 1);
    chk(rd, 32'h0000_0000);
    // Status idle after reset; it is read only
    apb(1'b0, 8'h7C, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
    chk(er, 0);
    apb(1'b1, 8'h7C, 32'hFFFF_FFFF);
    chk(er, 1);
    chk(pready, 1);
    for (int j = 0; j < 8; j++)
    begin
      for (int i = 0; i < 8; i++)
      begin
        r = rnd();
        sq[i] = r[2:0] == 3'h0 ? {1'b1, 5'h00, r[9:8]} + 8'h01 : {1'b0, r[14:8] | 7'h01};
      end
      if (j > 1 && r[4])
        sq[r[18:16]] = 8'h00;
      sq[0] = j == 0 ? 8'h00 : sq[0];
      run_seq();
    end
    test_done();
  end
endmodule
